// ==== hw/rc_setpoint_detector.sv ====
/*
  Setpoint detector: charges the setpoint capacitor, times its discharge,
  matches the time against 16 thresholds and outputs a reference current.
  Assumes the ADC delivers samples with adc_valid_i and a Wishbone master.
*/
// Design decisions made here: the register addresses and the Wishbone slave port.
module rc_setpoint_detector
  import rc_setpoint_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic startup_i,
  input wire logic open_recover_i,
  input wire logic adc_valid_i,
  input wire logic [adc_w-1:0] adc_data_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic charge_sw_o,
  output logic adc_req_o,
  output logic serial_en_o,
  output logic [cur_w-1:0] ref_current_o,
  output logic [grp_w-1:0] ref_group_o,
  output logic ref_valid_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  seq_state_t state;
  logic [adc_w-1:0] level;
  logic [time_w-1:0] charge_len;
  logic [time_w-1:0] timeout_len;
  logic [time_w-1:0] thr [entry_count];
  logic [cur_w-1:0] cur [entry_count];
  logic [time_w-1:0] measured;
  logic [idx_w-1:0] sel_idx;
  logic timed_out;
  logic done_flag;
  logic sw_start;
  logic wr;
  logic [time_w-1:0] charge_seen;
  interval_timer_if tif();

  interval_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tif(tif)
  );

  // First index whose threshold exceeds the time; last entry if none
  function automatic logic [idx_w-1:0] pick(input logic [time_w-1:0] t, input logic [time_w-1:0] th [entry_count]);
    logic [idx_w-1:0] r;
    logic found;
    r = 4'hF;
    found = 1'b0;
    for (int i = 0; i < entry_count; i++)
    begin
      if (!found && th[i] > t)
      begin
        r = idx_w'(i);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // ********************************
  // Register bus
  // ********************************
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level <= level_reset;
      charge_len <= time_w'(charge_cycles);
      timeout_len <= time_w'(timeout_cycles);
      for (int i = 0; i < entry_count; i++)
      begin
        thr[i] <= thr_step_reset * time_w'(i + 1);
        cur[i] <= cur_reset;
      end
    end
    else if (wr)
    begin
      if (wb_adr_i == level_addr)
        level <= wb_dat_i[adc_w-1:0];
      if (wb_adr_i == charge_addr)
        charge_len <= wb_dat_i[time_w-1:0];
      if (wb_adr_i == timeout_addr)
        timeout_len <= wb_dat_i[time_w-1:0];
      // Threshold words at 0x40..0x7C, currents at 0x80..0xBC
      if (wb_adr_i[7:6] == 2'b01)
        thr[wb_adr_i[5:2]] <= wb_dat_i[time_w-1:0];
      if (wb_adr_i[7:6] == 2'b10)
        cur[wb_adr_i[5:2]] <= wb_dat_i[cur_w-1:0];
    end
  end

  assign sw_start = wr && wb_adr_i == ctrl_addr && wb_dat_i[ctrl_start_bit];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else
    begin
      wb_dat_o <= 32'h00000000;
      if (wb_adr_i == status_addr)
        wb_dat_o <= {29'h0, timed_out, done_flag, state != st_idle && state != st_done};
      else if (wb_adr_i == level_addr)
        wb_dat_o <= {20'h0, level};
      else if (wb_adr_i == charge_addr)
        wb_dat_o <= {16'h0, charge_len};
      else if (wb_adr_i == timeout_addr)
        wb_dat_o <= {16'h0, timeout_len};
      else if (wb_adr_i == result_addr)
        wb_dat_o <= {10'h0, ref_group_o, sel_idx, measured};
      else if (wb_adr_i[7:6] == 2'b01)
        wb_dat_o <= {16'h0, thr[wb_adr_i[5:2]]};
      else if (wb_adr_i[7:6] == 2'b10)
        wb_dat_o <= {16'h0, cur[wb_adr_i[5:2]]};
    end
  end

  // ********************************
  // Sequencer
  // ********************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= st_idle;
    else
      unique case (state)
        st_idle, st_done:
          if (startup_i || open_recover_i || sw_start)
            state <= st_charge;
        st_charge:
          if (tif.count >= charge_len - 16'h0001)
            state <= st_discharge;
        st_discharge:
          if ((adc_valid_i && adc_data_i < level) || tif.count >= timeout_len)
            state <= st_compare;
        st_compare:
          state <= st_done;
      endcase
  end

  assign tif.clear = (state == st_charge && tif.count >= charge_len - 16'h0001) || state == st_idle ||
                     state == st_done;
  assign tif.run = state == st_charge || state == st_discharge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      measured <= '0;
      timed_out <= 1'b0;
    end
    else if (state == st_discharge)
    begin
      measured <= tif.count;
      timed_out <= !(adc_valid_i && adc_data_i < level) && tif.count >= timeout_len;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_idx <= 4'hF;
      done_flag <= 1'b0;
    end
    else if (state == st_compare)
    begin
      sel_idx <= timed_out ? 4'hF : pick(measured, thr);
      done_flag <= 1'b1;
    end
    else if (state == st_charge)
      done_flag <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_current_o <= cur_reset;
    else
      ref_current_o <= cur[sel_idx];
  end

  assign ref_group_o = sel_idx[idx_w-1:idx_w-grp_w];
  assign ref_valid_o = state == st_done;

  // ********************************
  // Pin control
  // ********************************
  // pin high with switch closed
  assign charge_sw_o = state == st_charge;
  assign pin_o = state == st_charge;
  assign pin_oe_o = state == st_charge;
  assign adc_req_o = state == st_discharge;
  assign serial_en_o = state == st_done;

  // ********************************
  // Checks
  // ********************************
  always_ff @(posedge clk_i)
    charge_seen <= (rst_i || !charge_sw_o) ? '0 : charge_seen + 16'h0001;
  property p_serial_off;
    @(posedge clk_i) disable iff (rst_i) (state == st_charge || state == st_discharge) |-> !serial_en_o;
  endproperty
  a_serial_off: assert property (p_serial_off) else $error("serial active while measuring");

  property p_trigger;
    @(posedge clk_i) disable iff (rst_i) ((state == st_idle || state == st_done) && (startup_i || open_recover_i))
      |=> state == st_charge;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not start detection");
  property p_charge_pin;
    @(posedge clk_i) disable iff (rst_i) charge_sw_o |-> (pin_o && pin_oe_o);
  endproperty
  a_charge_pin: assert property (p_charge_pin) else $error("charge without pin high");
  property p_charge_len;
    @(posedge clk_i) disable iff (rst_i) $fell(charge_sw_o) |-> charge_seen == charge_len;
  endproperty
  a_charge_len: assert property (p_charge_len) else $error("charge length differs from setting");

  property p_adc_disch;
    @(posedge clk_i) disable iff (rst_i) $fell(charge_sw_o) |-> adc_req_o && tif.count == 16'h0000;
  endproperty
  a_adc_disch: assert property (p_adc_disch) else $error("discharge timer not restarted");

  property p_cross;
    @(posedge clk_i) disable iff (rst_i) (state == st_discharge && adc_valid_i && adc_data_i < level)
      |=> state == st_compare && measured == $past(tif.count);
  endproperty
  a_cross: assert property (p_cross) else $error("crossing not latched");

  property p_timeout;
    @(posedge clk_i) disable iff (rst_i) (state == st_compare && timed_out) |=> sel_idx == 4'hF;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not pick last entry");

  property p_pick;
    @(posedge clk_i) disable iff (rst_i) (state == st_compare && !timed_out)
      |=> (sel_idx == 4'hF || thr[sel_idx] > measured) && (sel_idx == 4'h0 || thr[sel_idx - 4'h1] <= measured);
  endproperty
  a_pick: assert property (p_pick) else $error("selected threshold not above time");

  property p_cur;
    @(posedge clk_i) disable iff (rst_i) ref_valid_o |=> ref_current_o == $past(cur[sel_idx]);
  endproperty
  a_cur: assert property (p_cur) else $error("reference current mismatch");

  property p_release;
    @(posedge clk_i) disable iff (rst_i) serial_en_o |-> !pin_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("pin driven in serial mode");

  property p_group;
    @(posedge clk_i) disable iff (rst_i) ref_group_o == sel_idx[3:2];
  endproperty
  a_group: assert property (p_group) else $error("group mismatch");
endmodule // rc_setpoint_detector

// ==== hw/rc_setpoint_pkg.sv ====
/*
  Shared constants and types for the RC setpoint detector.
  Assumes a 10 MHz system clock and an external ADC that reports pin samples.
*/
package rc_setpoint_pkg;
  localparam int unsigned clk_hz = 10000000;
  // Charge duration default in microseconds
  localparam int unsigned charge_duration_us = 50;
  localparam int unsigned charge_cycles = (charge_duration_us * (clk_hz / 1000000));
  // Timeout default in microseconds
  localparam int unsigned discharge_timeout_us = 4000;
  localparam int unsigned timeout_cycles = (discharge_timeout_us * (clk_hz / 1000000));
  localparam int unsigned entry_count = 16;
  localparam int unsigned group_size = 4;
  localparam int unsigned time_w = 16;
  localparam int unsigned adc_w = 12;
  localparam int unsigned cur_w = 16;
  localparam int unsigned idx_w = 4;
  localparam int unsigned grp_w = 2;
  // Wishbone offsets
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] level_addr = 8'h08;
  localparam logic [7:0] charge_addr = 8'h0C;
  localparam logic [7:0] timeout_addr = 8'h10;
  localparam logic [7:0] result_addr = 8'h14;
  localparam logic [7:0] thr_base_addr = 8'h40;
  localparam logic [7:0] cur_base_addr = 8'h80;
  // Field positions
  localparam int unsigned ctrl_start_bit = 0;
  localparam int unsigned st_busy_bit = 0;
  localparam int unsigned st_done_bit = 1;
  localparam int unsigned st_timeout_bit = 2;
  // Reset values
  localparam logic [adc_w-1:0] level_reset = 12'h1F1;
  localparam logic [time_w-1:0] thr_step_reset = 16'h0100;
  localparam logic [cur_w-1:0] cur_reset = 16'h0000;
  typedef enum logic [2:0] {st_idle, st_charge, st_discharge, st_compare, st_done} seq_state_t;
endpackage

// ==== hw/rc_setpoint_if.sv ====
/*
  Timer interface between the sequencer and its interval timer.
  Assumes one clock domain.
*/
interface interval_timer_if;
  logic clear;
  logic run;
  logic [15:0] count;
  modport ctl(output clear, output run, input count);
  modport tmr(input clear, input run, output count);
endinterface

// ==== hw/interval_timer.sv ====
/*
  Saturating interval counter used for charge and discharge timing.
  Assumes synchronous active-high reset.
*/
module interval_timer
  import rc_setpoint_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  interval_timer_if.tmr tif
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tif.clear)
      tif.count <= '0;
    else if (tif.run && tif.count != 16'hFFFF)
      tif.count <= tif.count + 16'h0001;
  end
endmodule // interval_timer

// ==== dv/rc_network_model.sv ====
/*
  Behavioural setpoint resistor, capacitor and ADC at the shared pin.
  Assumes the detector's charge and sample request outputs, one clock.
*/
module rc_network_model
  import rc_setpoint_pkg::*;
(
  input wire logic clk_i,
  input wire logic charge_sw_i,
  input wire logic adc_req_i,
  input wire logic [time_w-1:0] hold_i,
  output logic adc_valid_o,
  output logic [adc_w-1:0] adc_data_o
);
  logic [time_w-1:0] elapsed;
  // Voltage stays high for hold_i samples, then drops; no sample is stale
  always_ff @(posedge clk_i)
  begin
    elapsed <= charge_sw_i ? '0 : (adc_req_i ? elapsed + 16'h0001 : elapsed);
    adc_valid_o <= adc_req_i;
    adc_data_o <= adc_req_i ? ((elapsed < hold_i) ? 12'hFFF : 12'h000) : ~adc_data_o;
  end
endmodule // rc_network_model

// ==== dv/rc_setpoint_detector_tb_top.sv ====
/*
  Self-checking bench for the setpoint detector.
  Assumes a Wishbone register map and the network model beside it.
*/
module rc_setpoint_detector_tb_top
  import rc_setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, startup_i = 0, open_recover_i = 0, adc_valid, pin_o, pin_oe_o, charge_sw_o;
  logic adc_req_o, serial_en_o, ref_valid_o, wb_ack_o, rv_q = 0, rv_qq = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [adc_w-1:0] adc_data;
  logic [cur_w-1:0] ref_current_o, cur_tab[16];
  logic [grp_w-1:0] ref_group_o;
  logic [time_w-1:0] hold = 16'h0000;
  logic [31:0] expq[$];
  int miscompares = 0, checked = 0, seed = 63388, k;

  always #50 clk_i = ~clk_i;

  rc_setpoint_detector DUT (.clk_i(clk_i), .rst_i(rst_i), .startup_i(startup_i),
    .open_recover_i(open_recover_i), .adc_valid_i(adc_valid), .adc_data_i(adc_data),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .charge_sw_o(charge_sw_o), .adc_req_o(adc_req_o),
    .serial_en_o(serial_en_o), .ref_current_o(ref_current_o), .ref_group_o(ref_group_o),
    .ref_valid_o(ref_valid_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  rc_network_model net (.clk_i(clk_i), .charge_sw_i(charge_sw_o), .adc_req_i(adc_req_o),
    .hold_i(hold), .adc_valid_o(adc_valid), .adc_data_o(adc_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Classic single cycle; waits for ack whatever its latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expq.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask

  // One detection run; expected index idx selects table entry and group
  // Trigger: 0 startup, 1 open-output recovery, 2 software start
  task automatic measure(input int idx, input logic [time_w-1:0] h, input logic [1:0] via);
    int n;
    n = 0;
    hold <= h;
    expq.push_back({14'h0, 2'(idx >> 2), cur_tab[idx]});
    if (via == 2'd2)
      wb(1'b1, ctrl_addr, 32'h00000001);
    else
    begin
      @(posedge clk_i);
      open_recover_i <= via[0];
      startup_i <= ~via[0];
      @(posedge clk_i);
      open_recover_i <= 1'b0;
      startup_i <= 1'b0;
    end
    while (charge_sw_o !== 1'b1) @(posedge clk_i);
    while (charge_sw_o === 1'b1)
    begin
      n++;
      @(posedge clk_i);
    end
    chk(n, 5);
    while (ref_valid_o !== 1'b1) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask

  // Result monitor: oldest note against each answer
  always @(posedge clk_i)
  begin
    if (wb_ack_o && wb_cyc_i && !wb_we_i) chk(wb_dat_o, expq.pop_front());
    if (ref_valid_o && rv_q && !rv_qq) chk({14'h0, ref_group_o, ref_current_o}, expq.pop_front());
    if (ref_valid_o && rv_q && !rv_qq) chk(serial_en_o, 1'b1);
    if (charge_sw_o || adc_req_o)
      chk({adc_req_o, serial_en_o, pin_oe_o, pin_o}, {~charge_sw_o, 1'b0, charge_sw_o, charge_sw_o});
    rv_qq <= rv_q;
    rv_q <= ref_valid_o;
  end

  initial
  begin
    #(100 * 40000);
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(level_addr, 32'h1F1);
    rd(charge_addr, 32'd500);
    rd(timeout_addr, 32'd40000);
    for (int i = 0; i < 16; i++)
    begin
      rd(thr_base_addr + 8'(4 * i), 32'(256 * (i + 1)));
      rd(cur_base_addr + 8'(4 * i), 32'h0);
    end
    // Short counts keep the run brief
    wb(1'b1, charge_addr, 32'd5);
    wb(1'b1, timeout_addr, 32'd3200);
    wb(1'b1, 8'h20, 32'hFFFF);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      cur_tab[i] = 16'($random(seed));
      wb(1'b1, cur_base_addr + 8'(4 * i), {16'h0, cur_tab[i]});
    end
    measure(0, 16'd128, 2'd0);
    rd(status_addr, 32'h2);
    rd(result_addr, {10'h0, 2'd0, 4'h0, 16'd129});
    measure(11, 16'd2944, 2'd1);
    repeat (3)
    begin
      k = ($random(seed) & 32'h7FFF) % 12;
      measure(k, 16'(k * 256 + 128), 2'(k % 3));
    end
    measure(15, 16'hFFFF, 2'd2);
    rd(status_addr, 32'h6);
    rd(result_addr, {10'h0, 2'd3, 4'hF, 16'd3200});
    close_out();
  end
endmodule // rc_setpoint_detector_tb_top
